// file: hdl/tces_timer_channel_event_status_irq.sv
// Purpose: Event status, interrupt mask and period register of one channel
// Assumes: Counter core supplies one-cycle event pulses on clk_sys
// Notes: Status read clears all event flags; a same-cycle event survives
//
// Summary of operation
// (RULE1) Counter wrap sets bit 0, read clears
// (RULE2) Double capture load sets overrun bit 1
// (RULE3) Waveform match A sets bit 2
// (RULE4) Waveform match B sets bit 3
// (RULE5) Match C sets bit 4 any mode
// (RULE6) Capture load A sets bit 5
// (RULE7) Capture load B sets bit 6
// (RULE8) External trigger sets bit 7
// (RULE9) Bit 16 shows live count clock state
// (RULE10) Bit 17 mirrors line A level
// (RULE11) Bit 18 mirrors line B level
// (RULE12) Enable write sets mask bits written one
// (RULE13) Disable write clears mask bits written one
// (RULE14) Mask reads enabled events, resets zero
// (RULE15) Period register reads its current value
// (RULE16) Interrupt while flag and mask both set
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module tces_timer_channel_event_status_irq
   import tces_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Counter core side
   input wire tces_evt_t evtIn,
   input wire logic waveMode,
   input wire logic countClockOn,
   input wire logic timer_line_a,
   input wire logic timer_line_b,
   input wire logic driveLineA,
   input wire logic driveLineB,
   input wire logic readCaptureA,
   input wire logic readCaptureB,
   output logic [15:0] periodValue,
   output logic irqOut
);

   // Register state and its next value
   tces_state_t st_q;
   tces_state_t st_d;
   // Decoded bus events of this cycle
   logic wrFire;
   logic rdFire;
   logic stRead;
   logic [7:0] setEvt;
   logic lineA;
   logic lineB;

   // Byte enable merge for a 16-bit field
   function automatic logic [15:0] mergeLow16(input logic [15:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = dat[7:0];
      end
      if (be[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction : mergeLow16

   // Handshake outputs
   assign s_axi_awready = !st_q.awHeld && !st_q.bValid;
   assign s_axi_wready = !st_q.wHeld && !st_q.bValid;
   assign s_axi_arready = !st_q.rValid;
   assign s_axi_bvalid = st_q.bValid;
   assign s_axi_bresp = st_q.bResp;
   assign s_axi_rvalid = st_q.rValid;
   assign s_axi_rdata = st_q.rData;
   assign s_axi_rresp = st_q.rResp;
   assign periodValue = st_q.period;
   // Interrupt level from flags gated by mask
   assign irqOut = |(st_q.flags & st_q.mask); // RULE16

   // Synchronised pin levels, second stage
   assign lineA = st_q.pinA[1];
   assign lineB = st_q.pinB[1];

   // Write fires once both address and data are held
   assign wrFire = st_q.awHeld && st_q.wHeld && !st_q.bValid;
   assign rdFire = s_axi_arvalid && s_axi_arready;
   assign stRead = rdFire && (s_axi_araddr == TCES_OFS_STATUS);

   // Event set terms, mode qualified except wrap, match C, trigger
   always_comb begin
      setEvt = TCES_EVT_RST;
      setEvt[TCES_BIT_WRAP] = evtIn.wrap; // RULE1
      setEvt[TCES_BIT_OVR] = !waveMode &&
         ((evtIn.loadA && st_q.pendA) ||
          (evtIn.loadB && st_q.pendB)); // RULE2
      setEvt[TCES_BIT_MA] = waveMode && evtIn.matchA; // RULE3
      setEvt[TCES_BIT_MB] = waveMode && evtIn.matchB; // RULE4
      setEvt[TCES_BIT_MC] = evtIn.matchC; // RULE5
      setEvt[TCES_BIT_CAPA] = !waveMode && evtIn.loadA; // RULE6
      setEvt[TCES_BIT_CAPB] = !waveMode && evtIn.loadB; // RULE7
      setEvt[TCES_BIT_ETRG] = evtIn.extTrig; // RULE8
   end

   // Next state
   always_comb begin
      st_d = st_q;
      // Pin synchronisers
      st_d.pinA = {st_q.pinA[1:0], timer_line_a};
      st_d.pinB = {st_q.pinB[1:0], timer_line_b};
      // Unread-capture tracking, load wins over read
      if (readCaptureA) begin
         st_d.pendA = 1'b0;
      end
      if (readCaptureB) begin
         st_d.pendB = 1'b0;
      end
      if (!waveMode && evtIn.loadA) begin
         st_d.pendA = 1'b1;
      end
      if (!waveMode && evtIn.loadB) begin
         st_d.pendB = 1'b1;
      end
      // Flags: read clears, new event wins
      if (stRead) begin
         st_d.flags = TCES_EVT_RST; // RULE1
      end
      st_d.flags = st_d.flags | setEvt;
      // Mode-excluded flags read zero
      if (waveMode) begin
         st_d.flags[TCES_BIT_OVR] = 1'b0; // RULE2
         st_d.flags[TCES_BIT_CAPA] = 1'b0; // RULE6
         st_d.flags[TCES_BIT_CAPB] = 1'b0; // RULE7
      end else begin
         st_d.flags[TCES_BIT_MA] = 1'b0; // RULE3
         st_d.flags[TCES_BIT_MB] = 1'b0; // RULE4
      end
      // Write channel capture
      if (s_axi_awvalid && s_axi_awready) begin
         st_d.awHeld = 1'b1;
         st_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_d.wHeld = 1'b1;
         st_d.wData = s_axi_wdata;
         st_d.wStrb = s_axi_wstrb;
      end
      // Write execution
      if (wrFire) begin
         st_d.awHeld = 1'b0;
         st_d.wHeld = 1'b0;
         st_d.bValid = 1'b1;
         st_d.bResp = TCES_RESP_OKAY;
         unique case (st_q.awAddr)
            TCES_OFS_PERIOD: begin
               st_d.period = mergeLow16(st_q.period, st_q.wData,
                                        st_q.wStrb);
            end
            TCES_OFS_IRQ_EN: begin
               if (st_q.wStrb[0]) begin
                  st_d.mask = st_q.mask | st_q.wData[7:0]; // RULE12
               end
            end
            TCES_OFS_IRQ_DIS: begin
               if (st_q.wStrb[0]) begin
                  st_d.mask = st_q.mask & ~st_q.wData[7:0]; // RULE13
               end
            end
            TCES_OFS_STATUS, TCES_OFS_IRQ_MASK: begin
               // Read-only: write ignored
               st_d.bResp = TCES_RESP_OKAY;
            end
            default: begin
               st_d.bResp = TCES_RESP_SLVERR;
            end
         endcase
      end else if (st_q.bValid && s_axi_bready) begin
         st_d.bValid = 1'b0;
      end
      // Read execution
      if (rdFire) begin
         st_d.rValid = 1'b1;
         st_d.rResp = TCES_RESP_OKAY;
         st_d.rData = '0;
         unique case (s_axi_araddr)
            TCES_OFS_PERIOD: begin
               st_d.rData[15:0] = st_q.period; // RULE15
            end
            TCES_OFS_STATUS: begin
               st_d.rData[7:0] = st_q.flags;
               st_d.rData[TCES_BIT_CLKON] = countClockOn; // RULE9
               st_d.rData[TCES_BIT_LINEA] =
                  waveMode ? driveLineA : lineA; // RULE10
               st_d.rData[TCES_BIT_LINEB] =
                  waveMode ? driveLineB : lineB; // RULE11
            end
            TCES_OFS_IRQ_MASK: begin
               st_d.rData[7:0] = st_q.mask; // RULE14
            end
            TCES_OFS_IRQ_EN, TCES_OFS_IRQ_DIS: begin
               // Write-only: reads as zero
               st_d.rResp = TCES_RESP_OKAY;
            end
            default: begin
               st_d.rResp = TCES_RESP_SLVERR;
            end
         endcase
      end else if (st_q.rValid && s_axi_rready) begin
         st_d.rValid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= '0;
         st_q.mask <= TCES_EVT_RST; // RULE14
         st_q.period <= TCES_PER_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // An unmasked event raises the interrupt one cycle later
   a_irq_level: assert property (@(posedge clk_sys) disable iff (reset)
      ((setEvt & st_q.mask) != TCES_EVT_RST) && !wrFire
      |=> irqOut) // RULE16
      else $error("irq not raised by unmasked event");

   // Wrap event visible one cycle later
   a_wrap_sets: assert property (@(posedge clk_sys) disable iff (reset)
      evtIn.wrap |=> st_q.flags[TCES_BIT_WRAP]) // RULE1
      else $error("wrap flag not set");

   // Overrun never seen in waveform mode
   a_ovr_wave: assert property (@(posedge clk_sys) disable iff (reset)
      waveMode && $past(waveMode) |-> !st_q.flags[TCES_BIT_OVR]) // RULE2
      else $error("overrun set in waveform mode");

   // Match A never in capture mode
   a_ma_capture: assert property (@(posedge clk_sys) disable iff (reset)
      !waveMode && !$past(waveMode) |-> !st_q.flags[TCES_BIT_MA]) // RULE3
      else $error("match A set in capture mode");

   // Match B set in waveform mode
   a_mb_sets: assert property (@(posedge clk_sys) disable iff (reset)
      waveMode && evtIn.matchB ##1 waveMode
      |-> st_q.flags[TCES_BIT_MB]) // RULE4
      else $error("match B flag not set");

   // Match C set in either mode
   a_mc_sets: assert property (@(posedge clk_sys) disable iff (reset)
      evtIn.matchC |=> st_q.flags[TCES_BIT_MC]) // RULE5
      else $error("match C flag not set");

   // Load A in capture mode sets its flag
   a_capa_sets: assert property (@(posedge clk_sys) disable iff (reset)
      !waveMode && evtIn.loadA ##1 !waveMode
      |-> st_q.flags[TCES_BIT_CAPA]) // RULE6
      else $error("capture A flag not set");

   // Load B in capture mode sets its flag
   a_capb_sets: assert property (@(posedge clk_sys) disable iff (reset)
      !waveMode && evtIn.loadB ##1 !waveMode
      |-> st_q.flags[TCES_BIT_CAPB]) // RULE7
      else $error("capture B flag not set");

   // Status read without events clears flags
   a_read_clear: assert property (@(posedge clk_sys) disable iff (reset)
      stRead && setEvt == TCES_EVT_RST |=> st_q.flags == TCES_EVT_RST) // RULE1
      else $error("flags survive status read");

   // Enable write sets the written bits
   a_en_sets: assert property (@(posedge clk_sys) disable iff (reset)
      wrFire && st_q.awAddr == TCES_OFS_IRQ_EN && st_q.wStrb[0]
      |=> (st_q.mask & $past(st_q.wData[7:0]))
          == $past(st_q.wData[7:0])) // RULE12
      else $error("enable write missed");

   // Disable write clears the written bits
   a_dis_clears: assert property (@(posedge clk_sys) disable iff (reset)
      wrFire && st_q.awAddr == TCES_OFS_IRQ_DIS && st_q.wStrb[0]
      |=> (st_q.mask & $past(st_q.wData[7:0])) == 8'h00) // RULE13
      else $error("disable write missed");

   // Mask holds when no mask write occurs
   a_mask_hold: assert property (@(posedge clk_sys) disable iff (reset)
      !wrFire |=> $stable(st_q.mask)) // RULE14
      else $error("mask changed without write");

   // Period read returns held value
   a_period_read: assert property (@(posedge clk_sys) disable iff (reset)
      rdFire && s_axi_araddr == TCES_OFS_PERIOD
      |=> s_axi_rdata[15:0] == $past(st_q.period)) // RULE15
      else $error("period read wrong");

   // Clock state bit is live
   a_clk_live: assert property (@(posedge clk_sys) disable iff (reset)
      stRead |=> s_axi_rdata[TCES_BIT_CLKON] == $past(countClockOn)) // RULE9
      else $error("clock state bit wrong");

   // Line mirrors in waveform mode
   a_line_mirror: assert property (@(posedge clk_sys) disable iff (reset)
      stRead && waveMode |=> s_axi_rdata[TCES_BIT_LINEA] == $past(driveLineA)
      && s_axi_rdata[TCES_BIT_LINEB] == $past(driveLineB)) // RULE10 RULE11
      else $error("line mirror wrong");

   // Match A set in waveform mode
   a_ma_sets: assert property (@(posedge clk_sys) disable iff (reset)
      waveMode && evtIn.matchA |=> st_q.flags[TCES_BIT_MA]) // RULE3
      else $error("match A flag not set");

   // Second unread load A in capture mode flags overrun
   a_ovr_sets: assert property (@(posedge clk_sys) disable iff (reset)
      !waveMode && evtIn.loadA && st_q.pendA
      |=> st_q.flags[TCES_BIT_OVR]) // RULE2
      else $error("overrun flag not set");

   // External trigger sets its flag in either mode
   a_etrg_sets: assert property (@(posedge clk_sys) disable iff (reset)
      evtIn.extTrig |=> st_q.flags[TCES_BIT_ETRG]) // RULE8
      else $error("trigger flag not set");

   // Match B never in capture mode
   a_mb_capture: assert property (@(posedge clk_sys) disable iff (reset)
      !waveMode && !$past(waveMode) |-> !st_q.flags[TCES_BIT_MB]) // RULE4
      else $error("match B set in capture mode");

   // Load A flag never in waveform mode
   a_capa_wave: assert property (@(posedge clk_sys) disable iff (reset)
      waveMode && $past(waveMode) |-> !st_q.flags[TCES_BIT_CAPA]) // RULE6
      else $error("capture A set in waveform mode");

   // Load B flag never in waveform mode
   a_capb_wave: assert property (@(posedge clk_sys) disable iff (reset)
      waveMode && $past(waveMode) |-> !st_q.flags[TCES_BIT_CAPB]) // RULE7
      else $error("capture B set in waveform mode");

   // Status read returns the flags held before clearing
   a_status_flags: assert property (@(posedge clk_sys) disable iff (reset)
      stRead |=> s_axi_rdata[7:0] == $past(st_q.flags)) // RULE1
      else $error("status flags read wrong");

   // Line mirrors follow the synchronised pins in capture mode
   a_line_capture: assert property (@(posedge clk_sys) disable iff (reset)
      stRead && !waveMode
      |=> s_axi_rdata[TCES_BIT_LINEA] == $past(lineA)
      && s_axi_rdata[TCES_BIT_LINEB] == $past(lineB)) // RULE10 RULE11
      else $error("line pin mirror wrong");

   // Write answered one cycle after address and data are held
   a_write_resp: assert property (@(posedge clk_sys) disable iff (reset)
      wrFire |=> s_axi_bvalid)
      else $error("write response missing");

   // Read answered one cycle after the address is taken
   a_read_resp: assert property (@(posedge clk_sys) disable iff (reset)
      rdFire |=> s_axi_rvalid)
      else $error("read response missing");

endmodule : tces_timer_channel_event_status_irq

// file: hdl/tces_pkg.sv
// Purpose: Shared constants and types for the timer channel event block
// Assumes: AXI4-Lite, 32-bit data, byte addresses as printed
// Notes: Event bit layout is shared by status, enable, disable and mask
package tces_pkg;
   // Register byte offsets
   localparam logic [7:0] TCES_OFS_PERIOD = 8'h1C;
   localparam logic [7:0] TCES_OFS_STATUS = 8'h20;
   localparam logic [7:0] TCES_OFS_IRQ_EN = 8'h24;
   localparam logic [7:0] TCES_OFS_IRQ_DIS = 8'h28;
   localparam logic [7:0] TCES_OFS_IRQ_MASK = 8'h2C;
   // Event field positions
   localparam int TCES_BIT_WRAP = 0;
   localparam int TCES_BIT_OVR = 1;
   localparam int TCES_BIT_MA = 2;
   localparam int TCES_BIT_MB = 3;
   localparam int TCES_BIT_MC = 4;
   localparam int TCES_BIT_CAPA = 5;
   localparam int TCES_BIT_CAPB = 6;
   localparam int TCES_BIT_ETRG = 7;
   localparam int TCES_NUM_EVT = 8;
   // Level field positions
   localparam int TCES_BIT_CLKON = 16;
   localparam int TCES_BIT_LINEA = 17;
   localparam int TCES_BIT_LINEB = 18;
   // Reset values
   localparam logic [7:0] TCES_EVT_RST = 8'h00;
   localparam logic [15:0] TCES_PER_RST = 16'h0000;
   // AXI responses
   localparam logic [1:0] TCES_RESP_OKAY = 2'h0;
   localparam logic [1:0] TCES_RESP_SLVERR = 2'h2;

   // Event inputs from the counter core, one-cycle pulses
   typedef struct packed {
      logic extTrig;
      logic loadB;
      logic loadA;
      logic matchC;
      logic matchB;
      logic matchA;
      logic wrap;
   } tces_evt_t;

   // Complete state of the block
   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] mask;
      logic pendA;
      logic pendB;
      logic [15:0] period;
      logic [2:0] pinA;
      logic [2:0] pinB;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } tces_state_t;
endpackage : tces_pkg

// file: tb/tb_tces_timer_channel_event_status_irq.sv
// Purpose: Register level test of the channel event and interrupt block
// Assumes: AXI4-Lite single-beat access, one clock domain
// Notes: Ready and valid are sampled mid-cycle, inputs move after rise
`timescale 1ns/10ps
module tb_tces_timer_channel_event_status_irq
   import tces_pkg::*;
;
   logic clk_sys = 1'b0; // System clock
   logic reset = 1'b1; // Synchronous reset
   logic [7:0] awAddr = 8'h00, arAddr = 8'h00; // Bus addresses
   logic [31:0] wData = 32'h0000_0000; // Write data
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0; // Write handshake
   logic arValid = 1'b0, rReady = 1'b0; // Read handshake
   logic awReady, wReady, bValid, arReady, rValid, irqOut; // Outputs
   logic [1:0] bResp, rResp; // Response codes
   logic [31:0] rData; // Read data
   logic [15:0] periodValue; // Period output
   tces_evt_t evtIn = '0; // Event pulses
   logic waveMode = 1'b0, clkOn = 1'b0; // Mode and clock state
   logic lineA = 1'b0, lineB = 1'b0, drvA = 1'b0, drvB = 1'b0; // Lines
   logic rdCapA = 1'b0, rdCapB = 1'b0; // Capture register reads
   int errors = 0; // Mismatches
   int checkCount = 0; // Comparisons

   // Device under test
   tces_timer_channel_event_status_irq uut (.clk_sys(clk_sys),
      .reset(reset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .evtIn(evtIn), .waveMode(waveMode),
      .countClockOn(clkOn), .timer_line_a(lineA), .timer_line_b(lineB),
      .driveLineA(drvA), .driveLineB(drvB), .readCaptureA(rdCapA),
      .readCaptureB(rdCapB), .periodValue(periodValue), .irqOut(irqOut));

   // Clock of 10 ns
   always #5 clk_sys = ~clk_sys;

   // Word comparison
   task automatic check_word(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   // Single bit comparison
   task automatic check_bit(input string what, input logic exp,
      input logic got);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   // Bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] expResp);
      logic aDone, wDone, tA, tW, bv;
      logic [1:0] r;
      aDone = 1'b0;
      wDone = 1'b0;
      @(posedge clk_sys);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      // Ready depends on registers only, so mid-cycle equals the edge
      while (!(aDone && wDone)) begin
         @(negedge clk_sys);
         tA = awValid && awReady;
         tW = wValid && wReady;
         @(posedge clk_sys);
         if (tA) begin
            awValid <= 1'b0;
            aDone = 1'b1;
         end
         if (tW) begin
            wValid <= 1'b0;
            wDone = 1'b1;
         end
      end
      // Hold bready until the response is seen at an edge
      do begin
         @(negedge clk_sys);
         bv = bValid;
         r = bResp;
         @(posedge clk_sys);
      end while (!bv);
      bReady <= 1'b0;
      check_word("write response", {30'h0, expResp}, {30'h0, r});
   endtask : wr

   // Bus read compared against expected data and response
   task automatic rd(input string what, input logic [7:0] a,
      input logic [31:0] exp, input logic [1:0] expResp);
      logic tA, rv;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clk_sys);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(negedge clk_sys);
         tA = arValid && arReady;
         @(posedge clk_sys);
      end while (!tA);
      arValid <= 1'b0;
      do begin
         @(negedge clk_sys);
         rv = rValid;
         d = rData;
         r = rResp;
         @(posedge clk_sys);
      end while (!rv);
      rReady <= 1'b0;
      check_word(what, exp, d);
      check_word("read response", {30'h0, expResp}, {30'h0, r});
   endtask : rd

   // One-cycle event pulse, then settle to mid-cycle
   task automatic pulse(input tces_evt_t e);
      @(posedge clk_sys);
      evtIn <= e;
      @(posedge clk_sys);
      evtIn <= '0;
      @(negedge clk_sys);
   endtask : pulse

   // Verdict and end of run
   task automatic end_of_test();
      $display("checks %0d errors %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      $display("unexpected watchdog expiry");
      end_of_test();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      rd("mask reset", TCES_OFS_IRQ_MASK, 32'h0, TCES_RESP_OKAY);
      rd("status reset", TCES_OFS_STATUS, 32'h0, TCES_RESP_OKAY);
      check_bit("irq reset", 1'b0, irqOut);
      // Mask set and clear, upper bits ignored
      wr(TCES_OFS_IRQ_EN, 32'hFFFF_FFA5, TCES_RESP_OKAY);
      rd("mask", TCES_OFS_IRQ_MASK, 32'hA5, TCES_RESP_OKAY);
      wr(TCES_OFS_IRQ_DIS, 32'hFFFF_FF21, TCES_RESP_OKAY);
      rd("mask", TCES_OFS_IRQ_MASK, 32'h84, TCES_RESP_OKAY);
      wr(TCES_OFS_IRQ_EN, 32'h02, TCES_RESP_OKAY);
      rd("mask", TCES_OFS_IRQ_MASK, 32'h86, TCES_RESP_OKAY);
      rd("unmapped", 8'h40, 32'h0, TCES_RESP_SLVERR);
      // Period register
      wr(TCES_OFS_PERIOD, 32'h0000_BEEF, TCES_RESP_OKAY);
      rd("period", TCES_OFS_PERIOD, 32'hBEEF, TCES_RESP_OKAY);
      check_word("period out", 32'hBEEF, {16'h0, periodValue});
      // Waveform mode: load flags excluded
      waveMode <= 1'b1;
      pulse('1);
      check_bit("irq wave", 1'b1, irqOut);
      wr(TCES_OFS_IRQ_DIS, 32'h84, TCES_RESP_OKAY);
      check_bit("irq masked", 1'b0, irqOut);
      wr(TCES_OFS_IRQ_EN, 32'h04, TCES_RESP_OKAY);
      check_bit("irq unmasked", 1'b1, irqOut);
      rd("status wave", TCES_OFS_STATUS, 32'h9D, TCES_RESP_OKAY);
      check_bit("irq cleared", 1'b0, irqOut);
      rd("status clear", TCES_OFS_STATUS, 32'h0, TCES_RESP_OKAY);
      // Capture mode: a read between loads avoids overrun
      waveMode <= 1'b0;
      pulse(7'h10); // Load A
      @(posedge clk_sys);
      rdCapA <= 1'b1;
      @(posedge clk_sys);
      rdCapA <= 1'b0;
      pulse(7'h10); // Load A
      rd("status load", TCES_OFS_STATUS, 32'h20, TCES_RESP_OKAY);
      pulse('1);
      rd("status capt", TCES_OFS_STATUS, 32'hF3, TCES_RESP_OKAY);
      pulse(7'h20); // Load B
      check_bit("irq overrun", 1'b1, irqOut);
      rd("status ovr b", TCES_OFS_STATUS, 32'h42, TCES_RESP_OKAY);
      rdCapB <= 1'b1;
      @(posedge clk_sys);
      rdCapB <= 1'b0;
      pulse(7'h20); // Load B
      rd("status no ovr", TCES_OFS_STATUS, 32'h40, TCES_RESP_OKAY);
      // Live levels: pins in capture mode, drives in waveform mode
      clkOn <= 1'b1;
      lineA <= 1'b1;
      drvB <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd("levels capt", TCES_OFS_STATUS, 32'h30000, TCES_RESP_OKAY);
      waveMode <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd("levels wave", TCES_OFS_STATUS, 32'h50000, TCES_RESP_OKAY);
      clkOn <= 1'b0;
      rd("clock off", TCES_OFS_STATUS, 32'h40000, TCES_RESP_OKAY);
      end_of_test();
   end
endmodule : tb_tces_timer_channel_event_status_irq
